// ===== logic/adc_ctrl_pkg.sv
// constants, types and register map of the converter control block
// assumes a 32-bit apb master and one 200 mhz clock
`default_nettype none
package adc_ctrl_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_SEL = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_RESULT = 12'h00C;
  localparam int ON_BIT = 0;
  localparam int START_BIT = 1;
  localparam int AUTO_BIT = 2;
  localparam int FREE_BIT = 3;
  localparam int DONE_BIT = 4;
  localparam int IE_BIT = 5;
  localparam int PS_LSB = 8;
  localparam int PS_W = 3;
  localparam int CH_LSB = 0;
  localparam int CH_W = 5;
  localparam int REF_LSB = 8;
  localparam int REF_W = 2;
  localparam int RES_W = 10;
  localparam int VALID_BIT = 16;
  localparam logic [4:0] LEN_EXT = 5'h19;
  localparam logic [4:0] LEN_NORM = 5'h0D;
  localparam logic [4:0] LEN_SYNC = 5'h0E;
  localparam logic [4:0] SH_EXT = 5'h0D;
  localparam logic [4:0] SH_NORM = 5'h01;
  localparam logic [4:0] SH_SYNC = 5'h02;
  localparam logic [4:0] ONE5 = 5'h01;
  localparam logic [4:0] TWO5 = 5'h02;
  localparam logic [9:0] RESULT_MAX = 10'h3FF;
  localparam logic [7:0] DIV_BASE = 8'h02;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {
    REF_EXT_PIN = 2'h0,
    REF_ANALOG_SUPPLY = 2'h1,
    REF_INTERNAL_2V56 = 2'h3
  } ref_t;
  typedef enum logic [2:0] {
    SLEEP_IDLE = 3'h0,
    SLEEP_NOISE = 3'h1,
    SLEEP_POWER_DOWN = 3'h2,
    SLEEP_POWER_SAVE = 3'h3,
    SLEEP_STANDBY = 3'h6
  } sleep_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ALIGN = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;
  typedef struct packed {
    logic [CH_W-1:0] channel_select_bits;
    logic [REF_W-1:0] reference_select_bits;
  } sel_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ===== logic/adc_seq_ctrl.sv
// sequencing and selection control of a 10-bit sar converter, apb slave
// assumes the analog front end returns its raw code at conversion end
// Function
// - differential conversions align to a clock at half the converter rate
// - user start with half-rate clock low takes 13 converter cycles
// - user start with half-rate clock high takes 14 converter cycles
// - free running restarts at once; automatic differential restarts take 14 cycles
// - auto-triggered differential conversion is marked invalid, except the extended first one after enable
// - temporary selection is copied to active selection until a start
// - active selection freezes during the conversion
// - copying resumes in the last converter cycle before completion
// - free running channel change affects only conversions after the next
// - reference is analog supply, internal 2.56 V or external pin
// - single-ended overrange saturates at 0x3FF without wrapping
// - idle or noise sleep starts a conversion once the cpu halts
// - completion request wakes the cpu from noise-reduction sleep
// - completion request is raised even if the cpu woke earlier
// - other sleep modes leave the converter enable untouched
// - first conversion after enable is extended, 25 converter cycles
// - start bit stays set while converting, cleared by hardware at end
// - auto-trigger rising edge resets prescaler and starts a conversion
//
// Our own choices: register access over APB and the placing of the registers.
`default_nettype none
module adc_seq_ctrl import adc_ctrl_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_trigger,
  input wire logic i_cpu_halted,
  input wire logic [2:0] i_sleep_mode,
  input wire logic [RES_W:0] i_fe_result,
  output logic o_conv_tick,
  output logic o_half_rate_conv_clock,
  output sel_t o_active_sel,
  output logic o_gain_stage_on,
  output logic o_sample_hold,
  output logic o_busy,
  output logic o_conv_irq
);
  logic rst_meta;
  logic rst_n;
  logic converter_on;
  logic conv_start_bit;
  logic auto_trigger_on;
  logic free_run;
  logic conv_done_flag;
  logic done_ie;
  logic [PS_W-1:0] ps;
  sel_t temp_sel;
  logic [RES_W-1:0] result;
  logic result_valid;
  logic run_valid;
  logic first_pend;
  logic user_pend;
  logic trig_q;
  logic halted_q;
  logic lock;
  logic [4:0] cnt;
  logic [4:0] conv_len;
  logic [4:0] sh_at;
  conv_state_t state;
  logic tick;
  logic half;
  logic diff;
  logic wr_acc;
  logic rd_acc;
  logic complete;
  logic free_again;
  logic trig_start;
  logic sleep_start;
  logic sleep_ok;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  conv_prescaler u_presc (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_run(converter_on),
    .i_restart(trig_start),
    .i_ps(ps),
    .o_tick(tick),
    .o_half_rate_conv_clock(half)
  );

  sel_holder u_sel (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_on(converter_on),
    .i_lock(lock),
    .i_temp(temp_sel),
    .o_active(o_active_sel),
    .o_diff(diff)
  );

  assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  assign complete = (state == ST_CONV) && tick && (cnt == conv_len - ONE5);
  assign free_again = complete && auto_trigger_on && free_run;
  // edges during a conversion or with the flag still set are ignored
  assign trig_start = converter_on && auto_trigger_on && !free_run && i_trigger && !trig_q
                      && (state == ST_IDLE) && !conv_done_flag;
  // other sleep modes are not recognised here, so enable is left alone
  assign sleep_ok = (i_sleep_mode == SLEEP_IDLE) || (i_sleep_mode == SLEEP_NOISE);
  assign sleep_start = converter_on && (state == ST_IDLE) && !conv_start_bit && !auto_trigger_on
                       && done_ie && sleep_ok && i_cpu_halted && !halted_q;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
      halted_q <= 1'b0;
    end else if (i_ce) begin
      trig_q <= i_trigger;
      halted_q <= i_cpu_halted;
    end
  end

  // apb: one wait state, so pready and prdata come from flops
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= ZERO32;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      if (i_psel && i_penable && !o_pready) begin
        o_prdata <= ZERO32;
        if (i_paddr == OFF_CTRL) begin
          o_prdata[ON_BIT] <= converter_on;
          o_prdata[START_BIT] <= conv_start_bit;
          o_prdata[AUTO_BIT] <= auto_trigger_on;
          o_prdata[FREE_BIT] <= free_run;
          o_prdata[DONE_BIT] <= conv_done_flag;
          o_prdata[IE_BIT] <= done_ie;
          o_prdata[PS_LSB +: PS_W] <= ps;
        end else if (i_paddr == OFF_SEL) begin
          o_prdata[CH_LSB +: CH_W] <= temp_sel.channel_select_bits;
          o_prdata[REF_LSB +: REF_W] <= temp_sel.reference_select_bits;
        end else if (i_paddr == OFF_STAT) begin
          o_prdata[CH_LSB +: CH_W] <= o_active_sel.channel_select_bits;
          o_prdata[REF_LSB +: REF_W] <= o_active_sel.reference_select_bits;
          o_prdata[VALID_BIT +: 3] <= state;
        end else if (i_paddr == OFF_RESULT) begin
          o_prdata[RES_W-1:0] <= result;
          o_prdata[VALID_BIT] <= result_valid;
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // control register; set by hardware wins over a software clear
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      converter_on <= 1'b0;
      auto_trigger_on <= 1'b0;
      free_run <= 1'b0;
      done_ie <= 1'b0;
      ps <= '0;
      temp_sel <= '0;
    end else if (i_ce && wr_acc && i_pstrb[0] && (i_paddr == OFF_CTRL)) begin
      converter_on <= i_pwdata[ON_BIT];
      auto_trigger_on <= i_pwdata[AUTO_BIT];
      free_run <= i_pwdata[FREE_BIT];
      done_ie <= i_pwdata[IE_BIT];
    end else if (i_ce && wr_acc && i_pstrb[1] && (i_paddr == OFF_CTRL)) begin
      ps <= i_pwdata[PS_LSB +: PS_W];
    end else if (i_ce && wr_acc && (i_paddr == OFF_SEL)) begin
      // reserved reference code falls back to the external pin
      if (i_pstrb[0]) begin
        temp_sel.channel_select_bits <= i_pwdata[CH_LSB +: CH_W];
      end
      if (i_pstrb[1]) begin
        if (i_pwdata[REF_LSB +: REF_W] == 2'h2) begin
          temp_sel.reference_select_bits <= REF_EXT_PIN;
        end else begin
          temp_sel.reference_select_bits <= i_pwdata[REF_LSB +: REF_W];
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_done_flag <= 1'b0;
    end else if (i_ce) begin
      if (complete) begin
        conv_done_flag <= 1'b1;
      end else if (wr_acc && i_pstrb[0] && (i_paddr == OFF_CTRL) && i_pwdata[DONE_BIT]) begin
        conv_done_flag <= 1'b0;
      end
    end
  end

  // extended conversion owed after every off-to-on of the enable
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_pend <= 1'b0;
    end else if (i_ce) begin
      if (!converter_on) begin
        first_pend <= 1'b1;
      end else if ((state == ST_ALIGN && tick) || trig_start) begin
        first_pend <= 1'b0;
      end
    end
  end

  // start bit: write of one, trigger or sleep sets it; end of a single clears it
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start_bit <= 1'b0;
      user_pend <= 1'b0;
    end else if (i_ce) begin
      if (!converter_on) begin
        conv_start_bit <= 1'b0;
        user_pend <= 1'b0;
      end else if (trig_start || sleep_start) begin
        conv_start_bit <= 1'b1;
        user_pend <= sleep_start;
      end else if (wr_acc && i_pstrb[0] && (i_paddr == OFF_CTRL) && i_pwdata[START_BIT] && !conv_start_bit) begin
        conv_start_bit <= 1'b1;
        user_pend <= 1'b1;
      end else if (complete && !free_again) begin
        conv_start_bit <= 1'b0;
      end else if (state == ST_ALIGN) begin
        user_pend <= 1'b0;
      end
    end
  end

  // sequencer
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
      conv_len <= LEN_NORM;
      sh_at <= SH_NORM;
      lock <= 1'b0;
      run_valid <= 1'b1;
    end else if (i_ce) begin
      case (state)
        ST_IDLE: begin
          lock <= 1'b0;
          if (trig_start) begin
            // prescaler restarts, so the gain stage had no steady clock
            state <= ST_CONV;
            cnt <= 5'h00;
            lock <= 1'b1;
            conv_len <= first_pend ? LEN_EXT : LEN_NORM;
            sh_at <= first_pend ? SH_EXT : SH_SYNC;
            run_valid <= first_pend || !diff;
          end else if (user_pend && converter_on) begin
            state <= ST_ALIGN;
          end
        end
        ST_ALIGN: begin
          if (!converter_on) begin
            state <= ST_IDLE;
          end else if (tick) begin
            state <= ST_CONV;
            cnt <= 5'h00;
            lock <= 1'b1;
            run_valid <= 1'b1;
            if (first_pend) begin
              conv_len <= LEN_EXT;
              sh_at <= SH_EXT;
            end else if (diff && half) begin
              conv_len <= LEN_SYNC;
              sh_at <= SH_SYNC;
            end else begin
              conv_len <= LEN_NORM;
              sh_at <= SH_NORM;
            end
          end
        end
        ST_CONV: begin
          if (!converter_on) begin
            state <= ST_IDLE;
            lock <= 1'b0;
          end else if (free_again) begin
            // next run locks the selection copied during the last cycle
            cnt <= 5'h00;
            lock <= 1'b1;
            conv_len <= diff ? LEN_SYNC : LEN_NORM;
            sh_at <= diff ? SH_SYNC : SH_NORM;
            run_valid <= 1'b1;
          end else if (complete) begin
            state <= ST_IDLE;
          end else if (tick) begin
            cnt <= cnt + ONE5;
            if (cnt == conv_len - TWO5) begin
              lock <= 1'b0;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // result capture; single-ended overrange clamps instead of wrapping
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
      result_valid <= 1'b0;
    end else if (i_ce && complete) begin
      if (!diff && i_fe_result[RES_W]) begin
        result <= RESULT_MAX;
      end else begin
        result <= i_fe_result[RES_W-1:0];
      end
      result_valid <= run_valid;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_conv_tick <= 1'b0;
      o_half_rate_conv_clock <= 1'b0;
      o_gain_stage_on <= 1'b0;
      o_sample_hold <= 1'b0;
      o_busy <= 1'b0;
      o_conv_irq <= 1'b0;
    end else if (i_ce) begin
      o_conv_tick <= tick;
      o_half_rate_conv_clock <= half;
      o_gain_stage_on <= converter_on && diff;
      o_sample_hold <= (state == ST_CONV) && tick && (cnt == sh_at);
      o_busy <= conv_start_bit;
      // level request held until the flag is cleared, whatever woke the cpu
      o_conv_irq <= conv_done_flag && done_ie;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n || !i_ce);

  chk_ext_length: assert property (state == ST_ALIGN && tick && first_pend && converter_on
    |=> conv_len == LEN_EXT) else $error("first conversion not extended");
  chk_sync_length: assert property (state == ST_ALIGN && tick && !first_pend && diff && half && converter_on
    |=> conv_len == LEN_SYNC) else $error("high phase start not 14 cycles");
  chk_low_length: assert property (state == ST_ALIGN && tick && !first_pend && !(diff && half) && converter_on
    |=> conv_len == LEN_NORM) else $error("low phase start not 13 cycles");
  chk_free_restart: assert property (free_again && converter_on && diff
    |=> state == ST_CONV && cnt == 5'h00 && conv_len == LEN_SYNC) else $error("free run restart wrong");
  chk_trig_invalid: assert property (trig_start && diff && !first_pend
    |=> !run_valid && state == ST_CONV) else $error("triggered differential run kept valid");
  chk_sel_frozen: assert property (lock && $past(lock)
    |-> $stable(o_active_sel)) else $error("selection moved while locked");
  chk_last_unlock: assert property (complete && !free_again
    |-> !lock) else $error("selection still locked at completion");
  chk_start_clear: assert property (complete && !free_again && converter_on
    |=> !conv_start_bit ##0 conv_done_flag) else $error("start bit not cleared at end");
  chk_half_restart: assert property (trig_start
    |=> ##1 !half) else $error("half-rate phase not restarted");
  chk_sleep_start: assert property (sleep_start
    |=> conv_start_bit ##1 state == ST_ALIGN) else $error("sleep did not start conversion");
  chk_irq_raise: assert property ($rose(conv_done_flag) && done_ie
    |=> o_conv_irq) else $error("completion request missing");
  chk_saturate: assert property (complete && !diff && i_fe_result[RES_W]
    |=> result == RESULT_MAX) else $error("overrange wrapped");

  cov_extended: cover property (complete && conv_len == LEN_EXT);
  cov_sync: cover property (complete && conv_len == LEN_SYNC);
  cov_trigger: cover property (trig_start);
  cov_sleep: cover property (sleep_start ##[1:400] complete);
endmodule : adc_seq_ctrl
`default_nettype wire

// ===== logic/conv_prescaler.sv
// converter clock prescaler with half-rate phase
// assumes run and restart come from logic on i_mclk
`default_nettype none
module conv_prescaler import adc_ctrl_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic [PS_W-1:0] i_ps,
  output logic o_tick,
  output logic o_half_rate_conv_clock
);
  logic [7:0] cnt;
  logic [7:0] div_last;
  assign div_last = (DIV_BASE << i_ps) - 8'h01;

  // held in reset while off or on a trigger, so lengths stay deterministic
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 8'h00;
      o_tick <= 1'b0;
      o_half_rate_conv_clock <= 1'b0;
    end else if (i_ce) begin
      if (!i_run || i_restart) begin
        cnt <= 8'h00;
        o_tick <= 1'b0;
        o_half_rate_conv_clock <= 1'b0;
      end else if (cnt >= div_last) begin
        cnt <= 8'h00;
        o_tick <= 1'b1;
        o_half_rate_conv_clock <= ~o_half_rate_conv_clock;
      end else begin
        cnt <= cnt + 8'h01;
        o_tick <= 1'b0;
      end
    end
  end
endmodule : conv_prescaler
`default_nettype wire

// ===== logic/sel_holder.sv
// active channel and reference selection behind the temporary register
// assumes lock is driven by the conversion sequencer on the same clock
`default_nettype none
module sel_holder import adc_ctrl_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_on,
  input wire logic i_lock,
  input wire sel_t i_temp,
  output sel_t o_active,
  output logic o_diff
);
  // copies continuously while unlocked; selection is dead while off
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_active <= '0;
      o_diff <= 1'b0;
    end else if (i_ce && i_on && !i_lock) begin
      o_active <= i_temp;
      o_diff <= |i_temp.channel_select_bits[CH_W-1:CH_W-2];
    end
  end
endmodule : sel_holder
`default_nettype wire

// ===== test/adc_sequencing_select_control_bench.sv
// self-checking bench of the converter control block
// assumes fe_model on the analog side and one 200 mhz clock
`default_nettype none
module adc_sequencing_select_control_bench import adc_ctrl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  logic mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, trig = 1'h0, halt = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] strb = 4'hF;
  logic [2:0] smode = 3'h0;
  logic [RES_W:0] fe;
  logic pready, pslverr, tick, hr, sh, busy, irq, gain, e;
  logic [31:0] prdata, q;
  sel_t asel;
  int failures = 0;
  int total_checks = 0;
  int n, l1;
  row_t rows [13] = '{
    '{1'h0, OFF_CTRL, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFF_STAT, 32'h0, 32'h0001_0000, 1'h0},
    '{1'h0, 12'h010, 32'h0, 32'h0, 1'h1},
    '{1'h1, 12'h010, 32'hFFFF_FFFF, 32'h0, 1'h1},
    '{1'h1, OFF_SEL, 32'h305, 32'h0, 1'h0},
    '{1'h0, OFF_STAT, 32'h0, 32'h0001_0000, 1'h0},
    '{1'h1, OFF_SEL, 32'h200, 32'h0, 1'h0},
    '{1'h0, OFF_SEL, 32'h0, 32'h0, 1'h0},
    '{1'h1, OFF_SEL, 32'h103, 32'h0, 1'h0},
    '{1'h1, OFF_CTRL, 32'h21, 32'h0, 1'h0},
    '{1'h0, OFF_STAT, 32'h0, 32'h0001_0103, 1'h0},
    '{1'h1, OFF_SEL, 32'h307, 32'h0, 1'h0},
    '{1'h0, OFF_STAT, 32'h0, 32'h0001_0307, 1'h0}};
  adc_seq_ctrl dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(1'h1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_trigger(trig), .i_cpu_halted(halt), .i_sleep_mode(smode), .i_fe_result(fe), .o_conv_tick(tick),
    .o_half_rate_conv_clock(hr), .o_active_sel(asel), .o_gain_stage_on(gain), .o_sample_hold(sh),
    .o_busy(busy), .o_conv_irq(irq));
  fe_model fe_i (.i_mclk(mclk), .i_sample(sh), .i_sel(asel), .o_code(fe));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; waits for pready with no assumed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'h1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    if (k >= 20) begin
      failures++;
    end
  endtask : apb
  // ticks seen until irq or sample pulse; first two cycles skipped so a tick seen while still idle is not counted
  // towards irq the start tick is dropped too, so a run counts its own cycles only
  task automatic meas(input logic to_sh, output int cnt);
    int k;
    cnt = to_sh ? 0 : -1;
    repeat (2) @(negedge mclk);
    for (k = 0; k < 400; k++) begin
      @(negedge mclk);
      if (tick === 1'h1) cnt++;
      if ((to_sh ? sh : irq) === 1'h1) break;
    end
  endtask : meas
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) begin
        chk(q, rows[i].q);
      end
      chk(32'(e), 32'(rows[i].e));
    end
    // slower converter clock gives the selection writes room
    strb <= 4'h2;
    apb(1'h1, OFF_CTRL, 32'h100);
    strb <= 4'hF;
    apb(1'h1, OFF_CTRL, 32'h33);
    fork
      meas(1'h0, n);
      begin
        repeat (8) @(posedge mclk);
        apb(1'h1, OFF_SEL, 32'h100);
        chk(32'(asel), 32'h1F);
        chk(32'(busy), 32'h1);
      end
    join
    chk(32'(n), 32'd25);
    chk(32'(busy), 32'h0);
    chk(32'(asel), 32'h01);
    apb(1'h0, OFF_RESULT, 32'h0);
    chk(q, 32'h0001_03FF);
    apb(1'h1, OFF_SEL, 32'h108);
    do @(negedge mclk); while (hr !== 1'h0);
    do @(negedge mclk); while (hr !== 1'h1);
    chk(32'(gain), 32'h1);
    apb(1'h1, OFF_CTRL, 32'h33);
    meas(1'h0, l1);
    do @(negedge mclk); while (hr !== 1'h1);
    do @(negedge mclk); while (hr !== 1'h0);
    apb(1'h1, OFF_CTRL, 32'h33);
    meas(1'h0, n);
    chk(32'(n * l1), 32'd182);
    apb(1'h1, OFF_CTRL, 32'h3F);
    meas(1'h0, n);
    repeat (4) @(posedge mclk);
    apb(1'h1, OFF_SEL, 32'h110);
    meas(1'h1, n);
    chk(32'(asel), 32'h21);
    meas(1'h1, n);
    chk(32'(n), 32'd14);
    chk(32'(asel), 32'h41);
    chk(32'(busy), 32'h1);
    apb(1'h1, OFF_CTRL, 32'h35);
    meas(1'h0, n);
    apb(1'h1, OFF_CTRL, 32'h35);
    trig <= 1'h1;
    meas(1'h0, n);
    apb(1'h0, OFF_RESULT, 32'h0);
    chk(q, 32'h0000_0030);
    trig <= 1'h0;
    apb(1'h1, OFF_CTRL, 32'h34);
    apb(1'h1, OFF_CTRL, 32'h35);
    trig <= 1'h1;
    meas(1'h0, n);
    apb(1'h0, OFF_RESULT, 32'h0);
    chk(q, 32'h0001_0030);
    trig <= 1'h0;
    apb(1'h1, OFF_CTRL, 32'h31);
    smode <= 3'h1;
    halt <= 1'h1;
    repeat (20) @(posedge mclk);
    halt <= 1'h0;
    meas(1'h0, n);
    chk(32'(irq), 32'h1);
    apb(1'h1, OFF_CTRL, 32'h31);
    smode <= 3'h2;
    halt <= 1'h1;
    repeat (200) @(posedge mclk);
    chk(32'(irq), 32'h0);
    apb(1'h0, OFF_CTRL, 32'h0);
    chk(q, 32'h0000_0121);
    wrap_up();
  end
endmodule : adc_sequencing_select_control_bench
`default_nettype wire

// ===== test/fe_model.sv
// analog front end model: input mux, gain stage and sar core
// assumes the sample pulse and active selection of the control block
`default_nettype none
module fe_model import adc_ctrl_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_sample,
  input wire sel_t i_sel,
  output logic [RES_W:0] o_code
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_code = 11'h000;
  end
  // code follows the channel; channel 7 sits above the reference, raw bits junk
  always @(posedge i_mclk) begin
    if (i_sample) begin
      o_code <= (i_sel.channel_select_bits == 5'h07) ? 11'h6AA : {6'h01, i_sel.channel_select_bits};
    end
  end
endmodule : fe_model
`default_nettype wire
